// file: design/i2c_host_map.vh
// constants for the two-wire host byte sequencer
// What this block does
// - transmit: buffer-full set on buffer write, cleared after eighth bit shifted out
// - buffer write during shifting in or out sets write-collision and is dropped
// - ack-status cleared on client ack low, set on client ack high
// - start-enable makes start, then irq flag; nothing else until it completes
// - buffer write starts eight-bit shift, samples ack, sets irq after ninth clock
// - receive-enable is ignored unless the unit is idle
// - receiving toggles SCL each baud rollover and shifts SDA into shift register
// - after eighth falling edge: clear receive-enable, load buffer, set flags, hold SCL
// - receive: buffer-full set on buffer load, cleared by buffer read
// - receive-overflow set when a byte completes while buffer-full still set
// - ack-enable pulls SCL low and drives ack-data bit onto SDA
// - ack: SCL low one baud period, release, one period high, low, go idle
// - irq flag set after acknowledge bit has been clocked out
// - stop: SDA low, once low count, release SCL, release SDA one period later
// - SDA high with SCL high sets stop-detected; one period later clear enable, irq
// - buffer writes during ack or stop sequence set write-collision and are dropped
// - reset or disable aborts transfer and clears start and stop detected flags
// - with irq enabled, a detected stop raises the irq flag
// - SDA compared with intended output in address, data, start, restart, ack phases
// - baud period is 2*(reload+1) clocks, SCL period twice that
// - bus collision sets its flag, returns to idle and releases both lines
`ifndef I2C_HOST_MAP_VH
`define I2C_HOST_MAP_VH

`define PHASE_0        2'h0
`define PHASE_1        2'h1
`define PHASE_2        2'h2
`define PHASE_3        2'h3
`define BIT_FIRST      4'h0
`define BIT_LAST_DATA  4'h7
`define BIT_ACK        4'h8
`define BIT_STEP       4'h1
`define FLAG_RESET     1'b0
`define BYTE_RESET     8'h00

`endif

// file: design/baud_counter.v
// reload down-counter that paces each SCL phase
`default_nettype none
`include "i2c_host_map.vh"

module baud_counter #(
  parameter RELOAD_W = 8
) (
  input  wire                clock,
  input  wire                sys_rst,
  input  wire [RELOAD_W-1:0] baud_reload,
  input  wire                run,
  output wire                rollover
);

  // doubled reload gives one baud period of 2*(reload+1) clocks
  wire [RELOAD_W:0] load_value = {baud_reload, 1'b1};
  reg  [RELOAD_W:0] count_reg;

  always @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= {(RELOAD_W+1){1'b0}};
    end else if (!run) begin
      // stalled counter stays loaded, so a restart always gives a full period
      count_reg <= load_value;
    end else if (count_reg == {(RELOAD_W+1){1'b0}}) begin
      count_reg <= load_value;
    end else begin
      count_reg <= count_reg - {{RELOAD_W{1'b0}}, 1'b1};
    end
  end

  assign rollover = run && (count_reg == {(RELOAD_W+1){1'b0}});

endmodule
`default_nettype wire

// file: design/bus_monitor.v
// start and stop condition watcher for the two-wire bus
`default_nettype none
`include "i2c_host_map.vh"

module bus_monitor (
  input  wire clock,
  input  wire sys_rst,
  input  wire unit_enable,
  input  wire sda_in,
  input  wire scl_in,
  output wire start_det,
  output wire stop_det,
  output reg  start_detected_flag,
  output reg  stop_detected_flag
);

  reg sda_prev_reg;

  assign start_det = scl_in && sda_prev_reg && !sda_in;
  assign stop_det  = scl_in && !sda_prev_reg && sda_in;

  always @(posedge clock) begin
    if (sys_rst || !unit_enable) begin
      sda_prev_reg        <= 1'b1;
      start_detected_flag <= `FLAG_RESET;
      stop_detected_flag  <= `FLAG_RESET;
    end else begin
      sda_prev_reg <= sda_in;
      if (start_det) begin
        start_detected_flag <= 1'b1;
        stop_detected_flag  <= 1'b0;
      end else if (stop_det) begin
        start_detected_flag <= 1'b0;
        stop_detected_flag  <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: design/i2c_host_byte_sequencer.v
// two-wire host sequencer: start, restart, byte transmit, receive, ack and stop
`default_nettype none
`include "i2c_host_map.vh"

module i2c_host_byte_sequencer #(
  parameter RELOAD_W = 8
) (
  input  wire                clock,
  input  wire                sys_rst,
  input  wire                unit_enable,
  input  wire [RELOAD_W-1:0] baud_reload_reg,
  input  wire                serial_irq_enable,
  input  wire                buf_wr_strobe,
  input  wire [7:0]          buf_wr_data,
  input  wire                buf_rd_strobe,
  input  wire                start_cmd,
  input  wire                restart_cmd,
  input  wire                stop_cmd,
  input  wire                receive_cmd,
  input  wire                ack_cmd,
  input  wire                ack_data_bit,
  input  wire                write_collision_clear,
  input  wire                serial_irq_clear,
  input  wire                receive_overflow_clear,
  input  wire                bus_collision_clear,
  input  wire                sda_in,
  output wire                sda_out,
  output wire                sda_oe,
  input  wire                scl_in,
  output wire                scl_out,
  output wire                scl_oe,
  output reg  [7:0]          serial_data_buffer,
  output reg                 buffer_full_flag,
  output reg                 write_collision_flag,
  output reg                 ack_status_flag,
  output reg                 receive_overflow_flag,
  output reg                 serial_irq_flag,
  output reg                 bus_collision_flag,
  output wire                start_detected_flag,
  output wire                stop_detected_flag,
  output reg                 start_enable,
  output reg                 restart_enable,
  output reg                 stop_enable,
  output reg                 receive_enable,
  output reg                 ack_sequence_enable,
  output wire                unit_idle
);

  localparam [6:0] S_IDLE    = 7'h01;
  localparam [6:0] S_START   = 7'h02;
  localparam [6:0] S_RESTART = 7'h04;
  localparam [6:0] S_TX      = 7'h08;
  localparam [6:0] S_RX      = 7'h10;
  localparam [6:0] S_ACK     = 7'h20;
  localparam [6:0] S_STOP    = 7'h40;

  reg [6:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] serial_shift_reg;
  reg       sda_low_reg;
  reg       scl_low_reg;

  wire start_det;
  wire stop_det;
  wire rollover;

  // open-drain: the pins are only ever pulled low
  assign sda_out   = 1'b0;
  assign scl_out   = 1'b0;
  assign sda_oe    = sda_low_reg;
  assign scl_oe    = scl_low_reg;
  assign unit_idle = (state_reg == S_IDLE);

  wire ph0 = (phase_reg == `PHASE_0);
  wire ph1 = (phase_reg == `PHASE_1);
  wire ph2 = (phase_reg == `PHASE_2);
  wire ph3 = (phase_reg == `PHASE_3);

  // after release, count only once SCL reads high so a stretching client keeps its time
  wire clocked_state = (state_reg == S_TX) || (state_reg == S_RX) || (state_reg == S_ACK);
  wire run = (state_reg == S_START) ||
             ((state_reg == S_RESTART) && (!ph1 || scl_in)) ||
             (clocked_state && (ph0 || scl_in)) ||
             ((state_reg == S_STOP) && ph0 && !sda_in) ||
             ((state_reg == S_STOP) && ph1 && scl_in) ||
             ((state_reg == S_STOP) && ph2 && !stop_det) ||
             ((state_reg == S_STOP) && ph3);

  // arbitration: a released SDA read low while SCL is high means another host won
  wire released_high = !sda_low_reg && !scl_low_reg && scl_in && !sda_in;
  wire check_phase   = ((state_reg == S_TX) && ph1 && (bit_cnt_reg != `BIT_ACK)) ||
                       ((state_reg == S_ACK) && ph1) ||
                       ((state_reg == S_RESTART) && ph1);
  wire collision     = (check_phase && released_high) ||
                       ((state_reg == S_START) && ph0 && (!sda_in || !scl_in)) ||
                       ((state_reg == S_STOP) && ph2 && rollover && !sda_in);

  wire tx_next_bit = !serial_shift_reg[6];
  wire [7:0] rx_byte = {serial_shift_reg[6:0], sda_in};

  baud_counter #(
    .RELOAD_W (RELOAD_W)
  ) u_baud_counter (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .baud_reload (baud_reload_reg),
    .run         (run),
    .rollover    (rollover)
  );

  bus_monitor u_bus_monitor (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .unit_enable         (unit_enable),
    .sda_in              (sda_in),
    .scl_in              (scl_in),
    .start_det           (start_det),
    .stop_det            (stop_det),
    .start_detected_flag (start_detected_flag),
    .stop_detected_flag  (stop_detected_flag)
  );

  always @(posedge clock) begin
    if (sys_rst || !unit_enable) begin
      state_reg             <= S_IDLE;
      phase_reg             <= `PHASE_0;
      bit_cnt_reg           <= `BIT_FIRST;
      serial_shift_reg      <= `BYTE_RESET;
      serial_data_buffer    <= `BYTE_RESET;
      sda_low_reg           <= 1'b0;
      scl_low_reg           <= 1'b0;
      buffer_full_flag      <= `FLAG_RESET;
      write_collision_flag  <= `FLAG_RESET;
      ack_status_flag       <= `FLAG_RESET;
      receive_overflow_flag <= `FLAG_RESET;
      serial_irq_flag       <= `FLAG_RESET;
      bus_collision_flag    <= `FLAG_RESET;
      start_enable          <= 1'b0;
      restart_enable        <= 1'b0;
      stop_enable           <= 1'b0;
      receive_enable        <= 1'b0;
      ack_sequence_enable   <= 1'b0;
    end else begin
      // clears first; any hardware set later in this block wins the same cycle
      if (write_collision_clear) begin
        write_collision_flag <= 1'b0;
      end
      if (serial_irq_clear) begin
        serial_irq_flag <= 1'b0;
      end
      if (receive_overflow_clear) begin
        receive_overflow_flag <= 1'b0;
      end
      if (bus_collision_clear) begin
        bus_collision_flag <= 1'b0;
      end
      if (buf_rd_strobe) begin
        buffer_full_flag <= 1'b0;
      end
      if (stop_det && serial_irq_enable) begin
        serial_irq_flag <= 1'b1;
      end
      if (buf_wr_strobe && (state_reg != S_IDLE)) begin
        write_collision_flag <= 1'b1;
      end

      if (collision) begin
        bus_collision_flag  <= 1'b1;
        state_reg           <= S_IDLE;
        phase_reg           <= `PHASE_0;
        sda_low_reg         <= 1'b0;
        scl_low_reg         <= 1'b0;
        start_enable        <= 1'b0;
        restart_enable      <= 1'b0;
        stop_enable         <= 1'b0;
        receive_enable      <= 1'b0;
        ack_sequence_enable <= 1'b0;
        if (state_reg == S_TX) begin
          buffer_full_flag <= 1'b0;
        end
      end else begin
        case (state_reg)
          S_IDLE: begin
            phase_reg   <= `PHASE_0;
            bit_cnt_reg <= `BIT_FIRST;
            // commands only act from idle, so nothing queues behind a running sequence
            if (buf_wr_strobe) begin
              serial_data_buffer <= buf_wr_data;
              serial_shift_reg   <= buf_wr_data;
              buffer_full_flag   <= 1'b1;
              sda_low_reg        <= !buf_wr_data[7];
              scl_low_reg        <= 1'b1;
              state_reg          <= S_TX;
            end else if (start_cmd) begin
              start_enable <= 1'b1;
              sda_low_reg  <= 1'b0;
              scl_low_reg  <= 1'b0;
              state_reg    <= S_START;
            end else if (restart_cmd) begin
              restart_enable <= 1'b1;
              sda_low_reg    <= 1'b0;
              scl_low_reg    <= 1'b1;
              state_reg      <= S_RESTART;
            end else if (stop_cmd) begin
              stop_enable <= 1'b1;
              sda_low_reg <= 1'b1;
              scl_low_reg <= 1'b1;
              state_reg   <= S_STOP;
            end else if (receive_cmd) begin
              receive_enable <= 1'b1;
              sda_low_reg    <= 1'b0;
              scl_low_reg    <= 1'b1;
              state_reg      <= S_RX;
            end else if (ack_cmd) begin
              ack_sequence_enable <= 1'b1;
              scl_low_reg         <= 1'b1;
              sda_low_reg         <= !ack_data_bit;
              state_reg           <= S_ACK;
            end
          end

          S_START: begin
            if (rollover && ph0) begin
              sda_low_reg <= 1'b1;
              phase_reg   <= `PHASE_1;
            end else if (rollover) begin
              scl_low_reg     <= 1'b1;
              start_enable    <= 1'b0;
              serial_irq_flag <= 1'b1;
              state_reg       <= S_IDLE;
            end
          end

          S_RESTART: begin
            if (rollover && ph0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= `PHASE_1;
            end else if (rollover && ph1) begin
              sda_low_reg <= 1'b1;
              phase_reg   <= `PHASE_2;
            end else if (rollover) begin
              scl_low_reg     <= 1'b1;
              restart_enable  <= 1'b0;
              serial_irq_flag <= 1'b1;
              state_reg       <= S_IDLE;
            end
          end

          S_TX: begin
            if (rollover && ph0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= `PHASE_1;
            end else if (rollover) begin
              scl_low_reg <= 1'b1;
              phase_reg   <= `PHASE_0;
              if (bit_cnt_reg == `BIT_ACK) begin
                ack_status_flag <= sda_in;
                serial_irq_flag <= 1'b1;
                sda_low_reg     <= 1'b0;
                state_reg       <= S_IDLE;
              end else begin
                serial_shift_reg <= {serial_shift_reg[6:0], 1'b0};
                bit_cnt_reg      <= bit_cnt_reg + `BIT_STEP;
                if (bit_cnt_reg == `BIT_LAST_DATA) begin
                  sda_low_reg      <= 1'b0;
                  buffer_full_flag <= 1'b0;
                end else begin
                  sda_low_reg <= tx_next_bit;
                end
              end
            end
          end

          S_RX: begin
            if (rollover && ph0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= `PHASE_1;
            end else if (rollover) begin
              serial_shift_reg <= rx_byte;
              scl_low_reg      <= 1'b1;
              phase_reg        <= `PHASE_0;
              bit_cnt_reg      <= bit_cnt_reg + `BIT_STEP;
              if (bit_cnt_reg == `BIT_LAST_DATA) begin
                receive_enable     <= 1'b0;
                serial_data_buffer <= rx_byte;
                buffer_full_flag   <= 1'b1;
                serial_irq_flag    <= 1'b1;
                state_reg          <= S_IDLE;
                if (buffer_full_flag) begin
                  receive_overflow_flag <= 1'b1;
                end
              end
            end
          end

          S_ACK: begin
            if (rollover && ph0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= `PHASE_1;
            end else if (rollover) begin
              scl_low_reg         <= 1'b1;
              ack_sequence_enable <= 1'b0;
              serial_irq_flag     <= 1'b1;
              state_reg           <= S_IDLE;
            end
          end

          S_STOP: begin
            if (rollover && ph0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= `PHASE_1;
            end else if (rollover && ph1) begin
              sda_low_reg <= 1'b0;
              phase_reg   <= `PHASE_2;
            end else if (ph2 && stop_det) begin
              phase_reg <= `PHASE_3;
            end else if (rollover && ph3) begin
              stop_enable     <= 1'b0;
              serial_irq_flag <= 1'b1;
              state_reg       <= S_IDLE;
            end
          end

          default: begin
            state_reg   <= S_IDLE;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: dv/i2c_host_props.sv
// port checker for the two-wire host byte sequencer
`default_nettype none
module i2c_host_props (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       unit_enable,
  input wire logic       buf_wr_strobe,
  input wire logic       receive_cmd,
  input wire logic       ack_data_bit,
  input wire logic       write_collision_clear,
  input wire logic       sda_oe,
  input wire logic       scl_oe,
  input wire logic [7:0] serial_data_buffer,
  input wire logic       buffer_full_flag,
  input wire logic       write_collision_flag,
  input wire logic       receive_overflow_flag,
  input wire logic       serial_irq_flag,
  input wire logic       bus_collision_flag,
  input wire logic       start_detected_flag,
  input wire logic       stop_detected_flag,
  input wire logic       start_enable,
  input wire logic       stop_enable,
  input wire logic       receive_enable,
  input wire logic       ack_sequence_enable,
  input wire logic       unit_idle
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  // disable acts as a full reset, so both gate the checks
  default disable iff (sys_rst || !unit_enable);
  property p_wr_bf; (buf_wr_strobe && unit_idle) |=> buffer_full_flag; endproperty
  a_wr_bf: assert property (p_wr_bf) else $error("write left full flag low");
  // a receive may legally load the buffer on the very edge of a refused write
  property p_write_collision_flag;
    (buf_wr_strobe && !unit_idle)
      |=> write_collision_flag && ($stable(serial_data_buffer) || $fell(receive_enable));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy write not refused");
  property p_write_collision_flag_hold; write_collision_flag && !write_collision_clear |=> write_collision_flag;
  endproperty
  a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision flag self-cleared");
  property p_rcv_ign; (receive_cmd && !unit_idle && !receive_enable) |=> !receive_enable;
  endproperty
  a_rcv_ign: assert property (p_rcv_ign) else $error("busy receive taken");
  property p_rx_done;
    $fell(receive_enable) && !bus_collision_flag |-> buffer_full_flag && serial_irq_flag && scl_oe;
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive end wrong");
  property p_ovf; $rose(receive_overflow_flag) |-> $past(buffer_full_flag); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without full buffer");
  property p_ack_drv;
    $rose(ack_sequence_enable) |-> scl_oe && (sda_oe != $past(ack_data_bit));
  endproperty
  a_ack_drv: assert property (p_ack_drv) else $error("ack level wrong");
  property p_start_end;
    $fell(start_enable) && !bus_collision_flag |-> serial_irq_flag && sda_oe && scl_oe;
  endproperty
  a_start_end: assert property (p_start_end) else $error("start end wrong");
  property p_stop_end;
    $fell(stop_enable) && !bus_collision_flag
      |-> serial_irq_flag && stop_detected_flag && !sda_oe && !scl_oe;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop end wrong");
  property p_bcl; $rose(bus_collision_flag) |-> !sda_oe && !scl_oe && unit_idle; endproperty
  a_bcl: assert property (p_bcl) else $error("collision kept lines");
  property p_reset;
    disable iff (1'b0) sys_rst |=> !start_detected_flag && !stop_detected_flag && !sda_oe && !scl_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state");
  c_rx: cover property ($fell(receive_enable));
  c_ovf: cover property ($rose(receive_overflow_flag));
  c_bcl: cover property ($rose(bus_collision_flag));
endmodule
bind i2c_host_byte_sequencer i2c_host_props chk (.clock, .sys_rst, .unit_enable, .buf_wr_strobe,
  .receive_cmd, .ack_data_bit, .write_collision_clear, .sda_oe, .scl_oe, .serial_data_buffer,
  .buffer_full_flag, .write_collision_flag, .receive_overflow_flag, .serial_irq_flag,
  .bus_collision_flag, .start_detected_flag, .stop_detected_flag, .start_enable, .stop_enable,
  .receive_enable, .ack_sequence_enable, .unit_idle);
`default_nettype wire

// file: dv/i2c_client_model.sv
// open-drain client model: acks, returns a byte, can pin data low
`default_nettype none
module i2c_client_model (
  input  wire logic       clock,
  input  wire logic       sda,
  input  wire logic       scl,
  input  wire logic       ack_low,
  input  wire logic       rd_mode,
  input  wire logic       hold_low,
  input  wire logic [7:0] tx_byte,
  output logic            sda_oe,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sda_q = 1'b1;
  logic       scl_q = 1'b1;
  logic [3:0] cnt   = 4'h0;
  always @(posedge clock) begin
    sda_q <= sda;
    scl_q <= scl;
    // a start parks the count so the clock fall that ends the start lands on bit zero
    if (scl && scl_q && sda_q && !sda)
      cnt <= 4'hF;
    else if (scl_q && !scl)
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    if (!scl_q && scl && cnt < 4'h8)
      rx_byte <= {rx_byte[6:0], sda};
  end
  // data bits change only while the clock line is low, hold_low pins data low at any time, a released line reads high
  assign sda_oe = hold_low | (cnt == 4'h8 && ack_low)
                | (cnt < 4'h8 && rd_mode && !tx_byte[3'h7 - cnt[2:0]]);
endmodule
`default_nettype wire

// file: dv/i2c_host_byte_sequencer_test.sv
// self-checking bench for the two-wire host byte sequencer
`default_nettype none
module i2c_host_byte_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] P_START = 8'h01, P_STOP = 8'h02, P_RCV = 8'h04, P_ACK = 8'h08;
  localparam logic [7:0] P_WR = 8'h10, P_WCLR = 8'h20, P_ICLR = 8'h40, P_RD = 8'h80;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       unit_enable = 1'b1;
  logic [7:0] pls = 8'h00;
  logic [7:0] buf_wr_data = 8'h00;
  logic       ack_data_bit = 1'b0;
  logic       cli_ack = 1'b0;
  logic       rd_mode = 1'b0;
  logic       hold = 1'b0;
  logic       rs = 1'b0;
  logic [7:0] cli_byte = 8'h00;
  logic [7:0] cli_rx;
  logic       sda_oe, scl_oe, cli_oe, unit_idle, start_enable, receive_enable;
  logic       buffer_full_flag, write_collision_flag, ack_status_flag, receive_overflow_flag;
  logic       serial_irq_flag, bus_collision_flag, start_detected_flag, stop_detected_flag;
  logic [7:0] serial_data_buffer;
  int         bad_count = 0;
  int         n_checks = 0;
  wire        sda = !(sda_oe | cli_oe);
  wire        scl = !scl_oe;
  always #10 clock = ~clock;
  i2c_host_byte_sequencer DUT (.clock, .sys_rst, .unit_enable, .baud_reload_reg(8'h03),
    .serial_irq_enable(1'b1), .buf_wr_strobe(pls[4]), .buf_wr_data, .buf_rd_strobe(pls[7]),
    .start_cmd(pls[0]), .restart_cmd(rs), .stop_cmd(pls[1]), .receive_cmd(pls[2]),
    .ack_cmd(pls[3]), .ack_data_bit, .write_collision_clear(pls[5]), .serial_irq_clear(pls[6]),
    .receive_overflow_clear(1'b0), .bus_collision_clear(1'b0), .sda_in(sda), .sda_out(),
    .sda_oe, .scl_in(scl), .scl_out(), .scl_oe, .serial_data_buffer, .buffer_full_flag,
    .write_collision_flag, .ack_status_flag, .receive_overflow_flag, .serial_irq_flag,
    .bus_collision_flag, .start_detected_flag, .stop_detected_flag, .start_enable,
    .restart_enable(), .stop_enable(), .receive_enable, .ack_sequence_enable(), .unit_idle);
  i2c_client_model cli (.clock, .sda, .scl, .ack_low(cli_ack), .rd_mode, .hold_low(hold),
    .tx_byte(cli_byte), .sda_oe(cli_oe), .rx_byte(cli_rx));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(input logic [7:0] p);
    pls = p;
    tick();
    pls = 8'h00;
    // one quiet edge so back-to-back pulses never reassign in one step
    tick();
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for the end of a sequence, then acknowledge its irq
  task automatic finish_op;
    int i;
    i = 0;
    tick();
    while (!(unit_idle === 1'b1 && serial_irq_flag === 1'b1) && i < 3000) begin
      tick();
      i++;
    end
    check(serial_irq_flag, 1'b1);
    pulse(P_ICLR);
  endtask
  // a write while busy must be dropped and the flag must wait for software
  task automatic collide;
    logic [7:0] keep;
    keep = serial_data_buffer;
    buf_wr_data = ~keep;
    pulse(P_WR);
    tick(2);
    check(write_collision_flag, 1'b1);
    check(serial_data_buffer, keep);
    pulse(P_WCLR);
    tick();
    check(write_collision_flag, 1'b0);
  endtask
  task automatic clean_state;
    check({start_detected_flag, stop_detected_flag, bus_collision_flag, unit_idle}, 8'h01);
    check({sda_oe, scl_oe, buffer_full_flag, serial_irq_flag}, 8'h00);
    $display("clean state done");
  endtask
  task automatic start_seq;
    check(stop_detected_flag | !start_detected_flag, 1'b1);
    pulse(P_START);
    check(start_enable, 1'b1);
    collide();
    finish_op();
    check({start_detected_flag, sda_oe, scl_oe}, 8'h07);
    $display("start done");
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    cli_ack = ack;
    buf_wr_data = b;
    pulse(P_WR);
    check(buffer_full_flag, 1'b1);
    pulse(P_RCV);
    check(receive_enable, 1'b0);
    collide();
    finish_op();
    check(buffer_full_flag, 1'b0);
    check(ack_status_flag, !ack);
    check(cli_rx, b);
    $display("send done");
  endtask
  task automatic recv(input logic [7:0] b, input logic ovf);
    cli_byte = b;
    pulse(P_RCV);
    check(receive_enable, 1'b1);
    collide();
    finish_op();
    check({receive_enable, buffer_full_flag, receive_overflow_flag}, {2'b01, ovf});
    check(serial_data_buffer, b);
    $display("receive done");
  endtask
  task automatic ack_seq(input logic nack);
    ack_data_bit = nack;
    pulse(P_ACK);
    check({scl_oe, sda_oe}, {1'b1, !nack});
    collide();
    finish_op();
    check(scl_oe, 1'b1);
    $display("ack done");
  endtask
  task automatic stop_seq;
    pulse(P_STOP);
    check(sda_oe, 1'b1);
    collide();
    finish_op();
    check({stop_detected_flag, sda_oe, scl_oe}, 8'h04);
    $display("stop done");
  endtask
  task automatic restart_seq;
    rs = 1'b1;
    tick();
    rs = 1'b0;
    tick();
    collide();
    finish_op();
    check({bus_collision_flag, start_detected_flag, sda_oe, scl_oe}, 8'h07);
    $display("restart done");
  endtask
  task automatic bus_clash;
    hold = 1'b1;
    tick(2);
    pulse(P_START);
    tick(2);
    check({bus_collision_flag, sda_oe, scl_oe, start_enable}, 8'h08);
    hold = 1'b0;
    tick(2);
    $display("collision done");
  endtask
  initial begin
    tick(10);
    sys_rst = 1'b0;
    tick();
    clean_state();
    start_seq();
    send(8'hA5, 1'b1);
    send(8'h5A, 1'b0);
    restart_seq();
    stop_seq();
    start_seq();
    send(8'hA7, 1'b1);
    rd_mode = 1'b1;
    cli_ack = 1'b0;
    recv(8'h3C, 1'b0);
    ack_seq(1'b0);
    recv(8'hC3, 1'b1);
    pulse(P_RD);
    check(buffer_full_flag, 1'b0);
    rd_mode = 1'b0;
    ack_seq(1'b1);
    stop_seq();
    bus_clash();
    unit_enable = 1'b0;
    tick(2);
    clean_state();
    complete_run();
  end
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
